/* logic/spimsp_pkg.sv */
package spimsp_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  // register byte addresses
  localparam logic [31:0] ADDR_STATUS  = 32'hffff0a00;
  localparam logic [31:0] ADDR_RX      = 32'hffff0a04;
  localparam logic [31:0] ADDR_TX      = 32'hffff0a08;
  localparam logic [31:0] ADDR_DIV     = 32'hffff0a0c;
  localparam logic [31:0] ADDR_CTRL    = 32'hffff0a10;
  localparam logic [31:0] ADDR_PWRCLK  = 32'hffff0a14;
  localparam logic [31:0] ADDR_IRQ_ST  = 32'hffff0a18;
  localparam logic [31:0] ADDR_IRQ_MSK = 32'hffff0a1c;
  localparam logic [31:0] STATUS_RST   = 32'h00000000;
  // control field positions
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_MASTER  = 1;
  localparam int unsigned CTRL_CPOL    = 2;
  localparam int unsigned CTRL_CPHA    = 3;
  localparam int unsigned CTRL_W       = 4;
  // power/clock control: source select in bits 7..6
  localparam int unsigned SRC_SEL_HI   = 7;
  localparam int unsigned SRC_SEL_LO   = 6;
  // status field positions
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_RX_FULL   = 1;
  localparam int unsigned ST_TX_EMPTY  = 2;
  localparam int unsigned ST_OVERRUN   = 3;
  localparam int unsigned ST_SEL_LVL   = 4;
  // interrupt bits
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_OVR      = 1;
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned BYTE_BITS    = 8;
  // rates
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned MAX_MBPS     = 20;
  localparam int unsigned SLV_MAX_MBPS = 10;
  localparam int unsigned DIV_RST      = 0;
  typedef enum logic [1:0] {spimsp_idle, spimsp_run, spimsp_last} spimsp_state_t;
endpackage

/* logic/spimsp_top.sv */
// Function
// - full duplex byte exchange up to 20 Mbps
// - master or slave selected by control
// - miso input as master, output as slave
// - mosi output as master, input as slave
// - eight bit words, msb first
// - byte takes exactly eight clock periods
// - sclk output as master, input as slave
// - sclk = source / (2*(1+divisor))
// - source chosen by power/clock bits 7:6
// - master polarity and phase from control
// - slave uses control mode, up to 10 Mbps
// - launch one edge, sample the other
// - slave exchanges bytes while select low
// - master drives select low during transfer
// - pins: select p1.1, sclk p1.0, miso p0.6, mosi p0.7
// - read-only 32-bit status, reset zero
`timescale 1ns/1ps
`default_nettype none
module spimsp_top #(
  parameter int unsigned DIV_W = 8  // divisor width
) (
  input  wire logic                          core_clk,        // 125 MHz
  input  wire logic                          reset,           // sync, high
  input  wire logic                          clk_en,          // freeze when low
  input  wire logic [spimsp_pkg::ADDR_W-1:0] bus_addr,        // byte address
  input  wire logic [spimsp_pkg::DATA_W-1:0] bus_wdata,       // write data
  input  wire logic                          bus_wr,          // write strobe
  input  wire logic                          bus_rd,          // read strobe
  output logic      [spimsp_pkg::DATA_W-1:0] bus_rdata,       // data cycle after read
  output logic                               irq,             // level interrupt
  input  wire logic [3:0]                    src_clk_tick,    // source clock enables
  input  wire logic                          port1_bit1_select_pin_i,  // select in
  output logic                               port1_bit1_select_pin_o,  // select out
  output logic                               port1_bit1_select_pin_oe_n, // low drives
  input  wire logic                          port1_bit0_clock_pin_i,   // sclk in
  output logic                               port1_bit0_clock_pin_o,   // sclk out
  output logic                               port1_bit0_clock_pin_oe_n, // low drives
  input  wire logic                          port0_bit6_miso_pin_i,    // miso in
  output logic                               port0_bit6_miso_pin_o,    // miso out
  output logic                               port0_bit6_miso_pin_oe_n, // low drives
  input  wire logic                          port0_bit7_mosi_pin_i,    // mosi in
  output logic                               port0_bit7_mosi_pin_o,    // mosi out
  output logic                               port0_bit7_mosi_pin_oe_n  // low drives
);
  import spimsp_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [DIV_W-1:0]  div_r;
  logic [7:0]        pwrclk_r;
  logic [7:0]        tx_r;
  logic              tx_full_r;
  logic [7:0]        rx_r;
  logic              rx_full_r;
  logic              ovr_r;
  logic [IRQ_W-1:0]  irq_st_r;
  logic [IRQ_W-1:0]  irq_msk_r;
  logic [7:0]        sh_r;
  logic [2:0]        bit_cnt_r;
  logic              sck_r;
  logic              half_r;
  logic [DIV_W-1:0]  dcnt_r;
  logic              done_p;
  logic              sclk_q_r;
  logic              sel_q_r;
  spimsp_state_t     st_r;

  wire is_master = ctrl_r[CTRL_MASTER];
  wire cpol      = ctrl_r[CTRL_CPOL];
  wire cpha      = ctrl_r[CTRL_CPHA];
  wire enabled   = ctrl_r[CTRL_EN];
  wire src_tick  = src_clk_tick[pwrclk_r[SRC_SEL_HI:SRC_SEL_LO]];
  wire wr_tx     = bus_wr && bus_addr == ADDR_TX;
  wire rd_rx     = bus_rd && bus_addr == ADDR_RX;
  wire sclk_in   = port1_bit0_clock_pin_i;
  wire s_edge    = sclk_in != sclk_q_r;
  wire s_lead    = s_edge && (sclk_in != cpol);
  wire sel_low   = !port1_bit1_select_pin_i;
  wire load_go   = enabled && (is_master ? tx_full_r : (sel_low && sel_q_r));
  // master half-period tick: one toggle per (1+divisor) source ticks
  wire m_tick    = src_tick && dcnt_r == div_r;
  // sample edge: leading when cpha=0, trailing when cpha=1
  wire m_lead    = m_tick && !half_r;
  wire lead_e    = is_master ? m_lead : s_lead;
  wire trail_e   = is_master ? (m_tick && half_r) : (s_edge && !s_lead);
  wire samp_e    = cpha ? trail_e : lead_e;
  wire shift_e   = cpha ? lead_e : trail_e;
  wire din       = is_master ? port0_bit6_miso_pin_i : port0_bit7_mosi_pin_i;
  logic samp_bit_r;

  // register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_r    <= '0;
      div_r     <= DIV_W'(DIV_RST);
      pwrclk_r  <= 8'h00;
      irq_msk_r <= '0;
    end else if (clk_en && bus_wr) begin
      unique case (bus_addr)
        ADDR_CTRL:    ctrl_r    <= bus_wdata[CTRL_W-1:0];
        ADDR_DIV:     div_r     <= bus_wdata[DIV_W-1:0];
        ADDR_PWRCLK:  pwrclk_r  <= bus_wdata[7:0];
        ADDR_IRQ_MSK: irq_msk_r <= bus_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // transmit holding byte
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_r      <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_tx) begin
        tx_r      <= bus_wdata[7:0];
        tx_full_r <= 1'b1;
      end else if (st_r == spimsp_idle && load_go) begin
        tx_full_r <= 1'b0;
      end else if (done_p && tx_full_r && !(is_master ? 1'b0 : sel_q_r)) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // slave pin samples; pins are synchronous to core_clk
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclk_q_r <= 1'b0;
      sel_q_r  <= 1'b1;
    end else if (clk_en) begin
      sclk_q_r <= port1_bit0_clock_pin_i;
      sel_q_r  <= port1_bit1_select_pin_i;
    end
  end

  // bit engine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r       <= spimsp_idle;
      sh_r       <= 8'h00;
      bit_cnt_r  <= 3'd0;
      sck_r      <= 1'b0;
      half_r     <= 1'b0;
      dcnt_r     <= '0;
      samp_bit_r <= 1'b0;
      done_p     <= 1'b0;
    end else if (clk_en) begin
      done_p <= 1'b0;
      unique case (st_r)
        spimsp_idle: begin
          sck_r  <= cpol;
          half_r <= 1'b0;
          dcnt_r <= '0;
          if (load_go) begin
            sh_r      <= tx_full_r ? tx_r : 8'hff;
            bit_cnt_r <= 3'd0;
            st_r      <= spimsp_run;
          end
        end
        spimsp_run: begin
          if (is_master && src_tick)
            dcnt_r <= m_tick ? '0 : dcnt_r + 1'b1;
          if (is_master && m_tick) begin
            sck_r  <= ~sck_r;
            half_r <= ~half_r;
          end
          if (!is_master && port1_bit1_select_pin_i)
            st_r <= spimsp_idle;
          else begin
            if (samp_e)
              samp_bit_r <= din;
            // cpha=1 launches on leading edges; the first bit is already out
            if (shift_e && cpha && bit_cnt_r != 3'd0)
              sh_r <= {sh_r[6:0], samp_bit_r};
            // shift after sampling; msb leaves first
            if (trail_e) begin
              if (!cpha || bit_cnt_r == 3'd7)
                sh_r <= {sh_r[6:0], cpha ? din : samp_bit_r};
              bit_cnt_r <= bit_cnt_r + 3'd1;
              if (bit_cnt_r == 3'd7) begin
                done_p <= 1'b1;
                st_r   <= spimsp_last;
              end
            end
          end
        end
        spimsp_last: begin
          // slave keeps going while selected, master if more data
          if (!is_master && !port1_bit1_select_pin_i) begin
            sh_r      <= tx_full_r ? tx_r : 8'hff;
            bit_cnt_r <= 3'd0;
            st_r      <= spimsp_run;
          end else if (is_master && tx_full_r) begin
            sh_r      <= tx_r;
            bit_cnt_r <= 3'd0;
            half_r    <= 1'b0;
            st_r      <= spimsp_run;
          end else
            st_r <= spimsp_idle;
        end
        default: st_r <= spimsp_idle;
      endcase
    end
  end

  // receive byte and overrun
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_r      <= 8'h00;
      rx_full_r <= 1'b0;
      ovr_r     <= 1'b0;
    end else if (clk_en) begin
      if (done_p) begin
        rx_r      <= sh_r;
        rx_full_r <= 1'b1;
        if (rx_full_r && !rd_rx)
          ovr_r <= 1'b1;
      end else if (rd_rx) begin
        rx_full_r <= 1'b0;
        ovr_r     <= 1'b0;
      end
    end
  end

  // sticky interrupts, set wins over write-one-clear
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_DONE] = done_p;
    irq_set[IRQ_OVR]  = done_p && rx_full_r && !rd_rx;
    irq_clr = (bus_wr && bus_addr == ADDR_IRQ_ST) ? bus_wdata[IRQ_W-1:0] : '0;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_st_r <= '0;
      irq      <= 1'b0;
    end else if (clk_en) begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
      irq      <= |(((irq_st_r & ~irq_clr) | irq_set) & irq_msk_r);
    end
  end

  // status word, read only
  logic [31:0] status;
  always_comb begin
    status              = STATUS_RST;
    status[ST_BUSY]     = st_r != spimsp_idle;
    status[ST_RX_FULL]  = rx_full_r;
    // gated by enable so the word reads zero out of reset
    status[ST_TX_EMPTY] = enabled && !tx_full_r;
    status[ST_OVERRUN]  = ovr_r;
    status[ST_SEL_LVL]  = enabled && sel_low;
  end

  always_ff @(posedge core_clk) begin
    if (reset)
      bus_rdata <= '0;
    else if (clk_en) begin
      bus_rdata <= '0;
      if (bus_rd) begin
        unique case (bus_addr)
          ADDR_STATUS:  bus_rdata <= status;
          ADDR_RX:      bus_rdata <= {24'h000000, rx_r};
          ADDR_TX:      bus_rdata <= {24'h000000, tx_r};
          ADDR_DIV:     bus_rdata <= 32'(div_r);
          ADDR_CTRL:    bus_rdata <= 32'(ctrl_r);
          ADDR_PWRCLK:  bus_rdata <= {24'h000000, pwrclk_r};
          ADDR_IRQ_ST:  bus_rdata <= 32'(irq_st_r);
          ADDR_IRQ_MSK: bus_rdata <= 32'(irq_msk_r);
          default:      bus_rdata <= '0;
        endcase
      end
    end
  end

  // pins, all registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port1_bit1_select_pin_o    <= 1'b1;
      port1_bit1_select_pin_oe_n <= 1'b1;
      port1_bit0_clock_pin_o     <= 1'b0;
      port1_bit0_clock_pin_oe_n  <= 1'b1;
      port0_bit6_miso_pin_o      <= 1'b0;
      port0_bit6_miso_pin_oe_n   <= 1'b1;
      port0_bit7_mosi_pin_o      <= 1'b0;
      port0_bit7_mosi_pin_oe_n   <= 1'b1;
    end else if (clk_en) begin
      port1_bit1_select_pin_o    <= !(is_master && st_r != spimsp_idle);
      port1_bit1_select_pin_oe_n <= !(enabled && is_master);
      port1_bit0_clock_pin_o     <= st_r == spimsp_run ? sck_r : cpol;
      port1_bit0_clock_pin_oe_n  <= !(enabled && is_master);
      // data pins hold outside run so the last sample edge sees no change
      if (st_r == spimsp_run) begin
        port0_bit7_mosi_pin_o    <= sh_r[7];
        port0_bit6_miso_pin_o    <= sh_r[7];
      end
      port0_bit7_mosi_pin_oe_n   <= !(enabled && is_master);
      port0_bit6_miso_pin_oe_n   <= !(enabled && !is_master && sel_low);
    end
  end

  // checks
  sequence s_byte_done;
    clk_en && done_p;
  endsequence

  sequence s_byte_kept;
    rx_full_r && irq_st_r[IRQ_DONE];
  endsequence

  property p_sel_idle;
    @(posedge core_clk) disable iff (reset)
    (clk_en && is_master && st_r == spimsp_idle && $past(st_r) == spimsp_idle)
      |=> port1_bit1_select_pin_o;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select not high while idle");

  property p_rx_flag;
    @(posedge core_clk) disable iff (reset)
    s_byte_done |=> s_byte_kept;
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("byte done not flagged");

  property p_status_ro;
    @(posedge core_clk) disable iff (reset)
    (bus_rd && bus_addr == ADDR_STATUS && clk_en) |=> bus_rdata[31:5] == 27'h0;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status upper bits not zero");

  // select must be low for the whole exchange, not only at its start
  property p_master_sel;
    @(posedge core_clk) disable iff (reset)
    (clk_en && is_master && st_r == spimsp_run) |=> !port1_bit1_select_pin_o;
  endproperty
  a_master_sel: assert property (p_master_sel) else $error("select high in transfer");

  property p_idle_sclk;
    @(posedge core_clk) disable iff (reset)
    (clk_en && st_r == spimsp_idle) |=> port1_bit0_clock_pin_o == $past(cpol);
  endproperty
  a_idle_sclk: assert property (p_idle_sclk) else $error("idle clock not at polarity");

  property p_slave_inputs;
    @(posedge core_clk) disable iff (reset)
    (clk_en && !is_master)
      |=> (port1_bit0_clock_pin_oe_n && port1_bit1_select_pin_oe_n
           && port0_bit7_mosi_pin_oe_n);
  endproperty
  a_slave_inputs: assert property (p_slave_inputs) else $error("slave drives a master pin");

  property p_slave_miso;
    @(posedge core_clk) disable iff (reset)
    (clk_en && enabled && !is_master && sel_low) |=> !port0_bit6_miso_pin_oe_n;
  endproperty
  a_slave_miso: assert property (p_slave_miso) else $error("slave not driving miso");

  // the byte counter wraps only at done, so eight trailing edges per byte
  property p_byte_end;
    @(posedge core_clk) disable iff (reset)
    (clk_en && st_r == spimsp_run && trail_e && bit_cnt_r == 3'd7
     && (is_master || !port1_bit1_select_pin_i))
      |=> (st_r == spimsp_last && done_p);
  endproperty
  a_byte_end: assert property (p_byte_end) else $error("byte did not end on eighth edge");
endmodule
`default_nettype wire

/* testbench/spimsp_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spimsp_slave_model (
  input  wire logic       sclk,    // from the master
  input  wire logic       sel_n,   // select, low active
  input  wire logic       mosi,    // data in
  input  wire logic       cpol,    // idle clock level
  input  wire logic       cpha,    // sample on trailing edge
  input  wire logic [7:0] tx_byte, // byte to return
  output logic            miso,    // data out
  output logic      [7:0] rx_byte, // byte taken in
  output int              n_smp    // sample edges seen
);
  initial miso = 1'b1;
  always @(negedge sel_n) begin
    n_smp = 0;
    if (!cpha) miso = tx_byte[7];
  end
  // released line floats to the pull-up level
  always @(posedge sel_n) miso = 1'b1;
  always @(sclk) begin
    if (!sel_n) begin
      if (sclk ^ cpol ^ cpha) begin
        rx_byte = {rx_byte[6:0], mosi};
        n_smp++;
      end else begin
        miso = tx_byte[7 - (n_smp % 8)];
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/spimsp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module spimsp_top_tb;
  import spimsp_pkg::*;
  logic        core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [31:0] bus_addr = '0, bus_wdata = '0, bus_rdata, rv;
  logic [3:0]  src_clk_tick = '0;
  logic        irq, sel_o, sel_oe_n, sck_o, sck_oe_n, miso_o, miso_oe_n, mosi_o, mosi_oe_n;
  logic        mdl_miso, tb_sel = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b1, cpol = 1'b0, cpha = 1'b0;
  logic [7:0]  mdl_tx = '0, mdl_rx, b_tx, b_rx, got;
  int          fail_count = 0, total_checks = 0, n_smp, cyc = 0, dv;
  real         lead_q[$];
  wire logic   sel_w  = sel_oe_n ? tb_sel : sel_o;
  wire logic   sck_w  = sck_oe_n ? tb_sck : sck_o;
  wire logic   mosi_w = mosi_oe_n ? tb_mosi : mosi_o;
  wire logic   miso_w = miso_oe_n ? mdl_miso : miso_o;

  always #4 core_clk = ~core_clk;
  // source k ticks once every k+1 core cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    src_clk_tick <= {cyc % 4 == 0, cyc % 3 == 0, cyc % 2 == 0, 1'b1};
  end
  always @(sck_w) if (!sel_w && sck_w !== cpol) lead_q.push_back($realtime);

  spimsp_top i_spimsp_top (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .irq(irq), .src_clk_tick(src_clk_tick),
    .port1_bit1_select_pin_i(sel_w), .port1_bit1_select_pin_o(sel_o),
    .port1_bit1_select_pin_oe_n(sel_oe_n), .port1_bit0_clock_pin_i(sck_w),
    .port1_bit0_clock_pin_o(sck_o), .port1_bit0_clock_pin_oe_n(sck_oe_n),
    .port0_bit6_miso_pin_i(miso_w), .port0_bit6_miso_pin_o(miso_o),
    .port0_bit6_miso_pin_oe_n(miso_oe_n), .port0_bit7_mosi_pin_i(mosi_w),
    .port0_bit7_mosi_pin_o(mosi_o), .port0_bit7_mosi_pin_oe_n(mosi_oe_n));
  spimsp_slave_model i_spimsp_slave_model (.sclk(sck_w), .sel_n(sel_w), .mosi(mosi_w),
    .cpol(cpol), .cpha(cpha), .tx_byte(mdl_tx), .miso(mdl_miso), .rx_byte(mdl_rx),
    .n_smp(n_smp));

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #700000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h8994));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_STATUS, rv);
    `CHK("status reset", STATUS_RST, rv)
    `CHK("select idle", 1'b1, sel_w)
    wr(ADDR_STATUS, 32'hffffffff);
    rd(ADDR_STATUS, rv);
    `CHK("status read only", STATUS_RST, rv)
    rd(32'hffff0a40, rv);
    `CHK("unmapped read", 32'h0, rv)
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} = 2'(m);
      dv = 3 + $urandom_range(2); // keeps the bit rate at or under 20 Mbps
      b_tx = 8'($urandom);
      mdl_tx = 8'($urandom);
      wr(ADDR_IRQ_MSK, {31'h0, m != 3});
      wr(ADDR_CTRL, {28'h0, cpha, cpol, 2'b11});
      wr(ADDR_DIV, 32'(dv));
      wr(ADDR_PWRCLK, 32'(m) << 6);
      lead_q.delete();
      wr(ADDR_TX, {24'h0, b_tx});
      rv = '0;
      for (int j = 0; j < 400 && rv[IRQ_DONE] !== 1'b1; j++) rd(ADDR_IRQ_ST, rv);
      if (rv[IRQ_DONE] !== 1'b1) begin
        fail_count++;
        tally_and_finish();
      end
      `CHK("mosi byte", b_tx, mdl_rx)
      `CHK("sample edges", 8, n_smp)
      `CHK("sclk span ns", 112 * (1 + dv) * (m + 1), int'(lead_q[7] - lead_q[0]))
      `CHK("irq level", m != 3, irq)
      if (m == 3) begin
        wr(ADDR_IRQ_MSK, 32'h1);
        repeat (2) @(posedge core_clk);
        `CHK("irq unmasked", 1'b1, irq)
      end
      rd(ADDR_STATUS, rv);
      `CHK("rx full", 1'b1, rv[ST_RX_FULL])
      rd(ADDR_RX, rv);
      `CHK("miso byte", mdl_tx, rv[7:0])
      `CHK("idle sclk", cpol, sck_w)
      `CHK("idle select", 1'b1, sel_w)
      `CHK("master drives", 3'b000, {sel_oe_n, sck_oe_n, mosi_oe_n})
      `CHK("miso input", 1'b1, miso_oe_n)
      wr(ADDR_IRQ_ST, 32'h1);
      repeat (2) @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
      $display("test master mode %0d done", m);
    end
    {cpol, cpha} = 2'b00;
    b_tx = 8'($urandom);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_TX, {24'h0, b_tx});
    `CHK("slave pins in", 3'b111, {sel_oe_n, sck_oe_n, mosi_oe_n})
    @(posedge core_clk);
    tb_sel <= 1'b0;
    for (int by = 0; by < 2; by++) begin
      b_rx = 8'($urandom);
      for (int i = 7; i >= 0; i--) begin
        @(posedge core_clk);
        tb_mosi <= b_rx[i];
        repeat (7) @(posedge core_clk); // 120 ns period stays under 10 Mbps
        got[i] = miso_w;
        tb_sck <= 1'b1;
        repeat (7) @(posedge core_clk);
        tb_sck <= 1'b0;
      end
      `CHK("slave miso", by == 0 ? b_tx : 8'hff, got)
      `CHK("slave drives miso", 1'b0, miso_oe_n)
      repeat (4) @(posedge core_clk);
      rd(ADDR_RX, rv);
      `CHK("slave rx", b_rx, rv[7:0])
    end
    @(posedge core_clk);
    tb_sel <= 1'b1;
    tb_mosi <= 1'b1;
    $display("test slave mode done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
